// ### shared/fpec_pkg.sv
// fpec_pkg: constants and types shared by the flash program/erase control block
package fpec_pkg;
  // ----------------------------------------------------------------
  // memory map (cpu addresses, byte address on apb is four times these)
  // ----------------------------------------------------------------
  localparam logic [15:0] FPEC_CTRL_IDX = 16'hFE08;
  localparam logic [15:0] FPEC_PROT_IDX = 16'hFF7E;
  localparam logic [15:0] FPEC_VECT_IDX = 16'hFFDC;
  localparam logic [15:0] FPEC_ARR_BASE = 16'hE000;
  localparam logic [15:0] FPEC_ARR_LAST = 16'hFFFF;
  localparam int FPEC_IDX_LSB = 2;
  localparam int FPEC_IDX_MSB = 17;
  localparam int FPEC_AW = 13;
  localparam int FPEC_DEPTH = 8192;
  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int FPEC_PAGE_BYTES = 64;
  localparam int FPEC_ROW_BYTES = 32;
  localparam int FPEC_PAGE_LSB = 6;
  localparam int FPEC_ROW_LSB = 5;
  localparam logic [7:0] FPEC_ERASED = 8'hFF;
  localparam logic [7:0] FPEC_BND_OPEN = 8'hFF;
  localparam logic [7:0] FPEC_BND_ALL = 8'h00;
  localparam logic [1:0] FPEC_BND_TOP = 2'h3;
  localparam logic [5:0] FPEC_BND_LOW = 6'h00;
  // ----------------------------------------------------------------
  // control register layout
  // ----------------------------------------------------------------
  localparam int FPEC_HV_BIT = 3;
  localparam int FPEC_MASS_BIT = 2;
  localparam int FPEC_ERASE_BIT = 1;
  localparam int FPEC_WSEL_BIT = 0;
  typedef struct packed {
    logic high_voltage_on;
    logic wipe_all;
    logic erase_select;
    logic write_select;
  } fpec_ctrl_t;
  localparam fpec_ctrl_t FPEC_CTRL_RST = 4'h0;
  // sequence progress
  typedef enum logic [3:0] {
    FPEC_IDLE = 4'b0001,
    FPEC_SEL = 4'b0010,
    FPEC_ARMED = 4'b0100,
    FPEC_LATCHED = 4'b1000
  } fpec_seq_t;
endpackage

// ### verilog/fpec_top.sv
// fpec_top: flash control and protect logic with its array, reached over apb
// Function
// - erased bit reads 1, programmed reads 0
// - 64-byte pages of two rows; erase clears page
// - decode control FE08, protect FF7E, vectors FFDC-FFFF
// - high voltage only after select and sequence
// - whole-array select makes erase cover 8K
// - erase and program never both set
// - program select latches address, not data
// - programming works on aligned 32-byte rows
// - protected range start to FFFF, high voltage refused unless test voltage; a mass erase latched below start still wipes it
// - protect zero locks all, all ones opens
// - non-FF protect locks itself unless test voltage; an erase covering it but latched at an unlocked address still wipes it
// - start address is 11, boundary bits, 000000
// - wait or stop aborts operation to standby
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
module fpec_top
(
  // clock, enable and reset
  input wire logic clk,
  input wire logic ce,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // system
  input wire logic cpu_sleep,
  input wire logic test_voltage,
  // array drive
  output logic pump_on,
  output logic array_standby
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] mem [0:fpec_pkg::FPEC_DEPTH-1];
  fpec_pkg::fpec_ctrl_t flash_control;
  fpec_pkg::fpec_seq_t seq;
  logic [fpec_pkg::FPEC_AW-1:0] lat_addr;
  logic [15:0] lat_full;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // protect start from the boundary byte
  function automatic logic [15:0] fpec_start(input logic [7:0] b);
    fpec_start = {fpec_pkg::FPEC_BND_TOP, b, fpec_pkg::FPEC_BND_LOW};
  endfunction

  // is a target locked against program or erase
  function automatic logic fpec_locked(input logic [15:0] a, input logic [7:0] b,
                                       input logic tv);
    logic hit;
    hit = 1'b0;
    if (b == fpec_pkg::FPEC_BND_ALL)
    begin
      hit = 1'b1;
    end
    else if (b != fpec_pkg::FPEC_BND_OPEN)
    begin
      hit = (a >= fpec_start(b)) || (a == fpec_pkg::FPEC_PROT_IDX);
    end
    fpec_locked = hit && !tv;
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic [15:0] cpu_addr = paddr[fpec_pkg::FPEC_IDX_MSB:fpec_pkg::FPEC_IDX_LSB];
  wire logic [fpec_pkg::FPEC_AW-1:0] arr_idx = cpu_addr[fpec_pkg::FPEC_AW-1:0];
  wire logic word_ok = (paddr[fpec_pkg::FPEC_IDX_LSB-1:0] == 2'h0)
                       && (paddr[31:fpec_pkg::FPEC_IDX_MSB+1] == 14'h0);
  wire logic hit_ctrl = word_ok && (cpu_addr == fpec_pkg::FPEC_CTRL_IDX);
  // array window includes the protect byte and the vector locations
  wire logic hit_arr = word_ok && (cpu_addr >= fpec_pkg::FPEC_ARR_BASE)
                       && (cpu_addr <= fpec_pkg::FPEC_ARR_LAST);
  wire logic hit_prot = word_ok && (cpu_addr == fpec_pkg::FPEC_PROT_IDX);
  wire logic [7:0] boundary_bits = mem[fpec_pkg::FPEC_PROT_IDX[fpec_pkg::FPEC_AW-1:0]];

  wire logic setup = ce && psel && !penable && !pready;
  wire logic done = ce && psel && penable && pready;
  wire logic wr_done = done && pwrite && !pslverr;
  wire logic rd_done = done && !pwrite && !pslverr;

  // control write request
  wire fpec_pkg::fpec_ctrl_t wr_ctrl = pwdata[fpec_pkg::FPEC_HV_BIT:fpec_pkg::FPEC_WSEL_BIT];
  wire logic both_sel = wr_ctrl.erase_select && wr_ctrl.write_select;
  wire logic any_sel = flash_control.erase_select || flash_control.write_select;
  wire logic tgt_locked = fpec_locked(lat_full, boundary_bits, test_voltage);
  // high voltage may rise only after select, protect read and a latched address
  wire logic hv_allow = (wr_ctrl.erase_select || wr_ctrl.write_select)
                        && (seq == fpec_pkg::FPEC_LATCHED) && !tgt_locked;
  wire logic hv_rise = wr_ctrl.high_voltage_on && !flash_control.high_voltage_on;
  wire logic ctrl_wr = wr_done && hit_ctrl;
  wire logic arr_wr = wr_done && hit_arr;

  wire fpec_pkg::fpec_ctrl_t next_ctrl = '{
    high_voltage_on: wr_ctrl.high_voltage_on && (!hv_rise || hv_allow),
    wipe_all: wr_ctrl.wipe_all,
    erase_select: wr_ctrl.erase_select,
    write_select: wr_ctrl.write_select
  };

  // erase fires when erase select drops while high voltage is on
  wire logic erase_fire = ctrl_wr && flash_control.erase_select
                          && !wr_ctrl.erase_select && flash_control.high_voltage_on;
  // byte program: latched row, high voltage on, target row matches
  wire logic same_row = (arr_idx[fpec_pkg::FPEC_AW-1:fpec_pkg::FPEC_ROW_LSB]
                         == lat_addr[fpec_pkg::FPEC_AW-1:fpec_pkg::FPEC_ROW_LSB]);
  wire logic prog_fire = arr_wr && flash_control.write_select
                         && flash_control.high_voltage_on && same_row
                         && !fpec_locked(cpu_addr, boundary_bits, test_voltage);

  // ----------------------------------------------------------------
  // apb response
  // ----------------------------------------------------------------
  wire logic unmapped = !(hit_ctrl || hit_arr);
  wire logic refuse = pwrite && hit_ctrl && both_sel;
  wire logic [31:0] rd_val = hit_ctrl ? {28'h0, flash_control}
                             : hit_arr ? {24'h0, mem[arr_idx]} : 32'h0;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else if (ce)
    begin
      pready <= setup;
      pslverr <= setup && (unmapped || refuse);
      prdata <= (setup && !pwrite) ? rd_val : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // control register and sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      flash_control <= fpec_pkg::FPEC_CTRL_RST;
      seq <= fpec_pkg::FPEC_IDLE;
      lat_addr <= '0;
      lat_full <= 16'h0;
    end
    else if (ce)
    begin
      if (cpu_sleep)
      begin
        flash_control <= fpec_pkg::FPEC_CTRL_RST;
        seq <= fpec_pkg::FPEC_IDLE;
      end
      else
      begin
        if (ctrl_wr)
        begin
          flash_control <= next_ctrl;
        end
        case (seq)
          fpec_pkg::FPEC_IDLE:
          begin
            if (ctrl_wr && (wr_ctrl.erase_select || wr_ctrl.write_select))
            begin
              seq <= fpec_pkg::FPEC_SEL;
            end
          end
          fpec_pkg::FPEC_SEL:
          begin
            if (rd_done && hit_prot)
            begin
              seq <= fpec_pkg::FPEC_ARMED;
            end
          end
          fpec_pkg::FPEC_ARMED:
          begin
            if (arr_wr)
            begin
              seq <= fpec_pkg::FPEC_LATCHED;
              lat_addr <= arr_idx;
              lat_full <= cpu_addr;
            end
          end
          fpec_pkg::FPEC_LATCHED:
          begin
          end
          default:
          begin
            seq <= fpec_pkg::FPEC_IDLE;
          end
        endcase
        // sequence ends once both selects and high voltage are gone
        if (ctrl_wr && !next_ctrl.erase_select && !next_ctrl.write_select
            && !next_ctrl.high_voltage_on)
        begin
          seq <= fpec_pkg::FPEC_IDLE;
        end
        else if (!any_sel && !flash_control.high_voltage_on && seq != fpec_pkg::FPEC_IDLE
                 && !ctrl_wr)
        begin
          seq <= fpec_pkg::FPEC_IDLE;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // array
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (ce && !reset && !cpu_sleep)
    begin
      if (erase_fire)
      begin
        for (int i = 0; i < fpec_pkg::FPEC_DEPTH; i++)
        begin
          if (flash_control.wipe_all
              || (i[fpec_pkg::FPEC_AW-1:fpec_pkg::FPEC_PAGE_LSB]
                  == lat_addr[fpec_pkg::FPEC_AW-1:fpec_pkg::FPEC_PAGE_LSB]))
          begin
            mem[i] <= fpec_pkg::FPEC_ERASED;
          end
        end
      end
      else if (prog_fire)
      begin
        mem[arr_idx] <= mem[arr_idx] & pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // array drive outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pump_on <= 1'b0;
      array_standby <= 1'b1;
    end
    else if (ce)
    begin
      pump_on <= ctrl_wr ? next_ctrl.high_voltage_on && !cpu_sleep
                 : flash_control.high_voltage_on && !cpu_sleep;
      array_standby <= cpu_sleep;
    end
  end
endmodule

// ### test/fpec_top_sva.sv
// checker for the apb side, array drive and control interlocks of fpec_top
`timescale 1ns/1ns
module fpec_chk
(
  // clock, enable and reset
  input wire logic clk,
  input wire logic ce,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // system and array drive
  input wire logic cpu_sleep,
  input wire logic test_voltage,
  input wire logic pump_on,
  input wire logic array_standby
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire ctrl_hit = paddr == {14'h0, fpec_pkg::FPEC_CTRL_IDX, 2'h0};
  // ----------------------------------------------------------------
  // sequences and properties
  // ----------------------------------------------------------------
  sequence s_setup;
    psel && !penable && !pready && ce;
  endsequence
  sequence s_hv_write;
    pready && psel && penable && pwrite && ctrl_hit && pwdata[3] && !pslverr;
  endsequence
  property p_answer;
    s_setup |=> pready;
  endproperty
  property p_one_cycle;
    pready |=> !pready;
  endproperty
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  property p_rdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  property p_standby;
    ce && !reset |=> array_standby == $past(cpu_sleep);
  endproperty
  property p_sleep_pump;
    ce && cpu_sleep |=> !pump_on;
  endproperty
  property p_both_refused;
    pready && psel && penable && pwrite && ctrl_hit && pwdata[1:0] == 2'h3 |-> pslverr;
  endproperty
  property p_pump_cause;
    $rose(pump_on) |-> $past(pready && pwrite && ctrl_hit && pwdata[3]);
  endproperty
  // ----------------------------------------------------------------
  // assertions and cover
  // ----------------------------------------------------------------
  a_answer: assert property (p_answer) else $error("no answer after setup");
  a_one_cycle: assert property (p_one_cycle) else $error("ready longer than one cycle");
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
  a_standby: assert property (p_standby) else $error("standby not following sleep");
  a_sleep_pump: assert property (p_sleep_pump) else $error("pump on while asleep");
  a_both_refused: assert property (p_both_refused) else $error("both selects accepted");
  a_pump_cause: assert property (p_pump_cause) else $error("pump on without hv write");
  c_hv: cover property (s_hv_write ##1 pump_on);
endmodule
bind fpec_top fpec_chk u_chk (.clk(clk), .ce(ce), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cpu_sleep(cpu_sleep), .test_voltage(test_voltage),
  .pump_on(pump_on), .array_standby(array_standby));

// ### test/flash_program_erase_control_tb_top.sv
// self-checking bench for the flash program/erase control block
`timescale 1ns/1ns
module flash_program_erase_control_tb_top;
  localparam logic [15:0] CTRL = fpec_pkg::FPEC_CTRL_IDX;
  localparam logic [15:0] PROT = fpec_pkg::FPEC_PROT_IDX;
  logic clk = 1'b0, reset = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic cpu_sleep = 1'b0, test_voltage = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, pump_on, array_standby, erv;
  int err_total = 0, checked = 0, cycles = 0;
  fpec_top dut (.clk(clk), .ce(ce), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_sleep(cpu_sleep), .test_voltage(test_voltage),
    .pump_on(pump_on), .array_standby(array_standby));
  always #4 clk = ~clk;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // the bench stands for cpu code running from ram
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {14'h0, a, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic e);
    xfer(1'b1, a, d);
    check({31'h0, erv}, {31'h0, e});
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    check(rdv, {24'h0, exp});
  endtask
  task automatic arm(input logic [7:0] sel, input logic [15:0] a, input logic [7:0] exp);
    wr(CTRL, sel, 1'b0);
    xfer(1'b0, PROT, 8'h00);
    wr(a, 8'h00, 1'b0);
    wr(CTRL, sel | 8'h08, 1'b0);
    rd(CTRL, exp);
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      results();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    check({31'h0, array_standby}, 32'h1);
    reset <= 1'b0;
    rd(CTRL, 8'h00);
    wr(CTRL, 8'h03, 1'b1);
    rd(CTRL, 8'h00);
    wr(16'h1000, 8'h01, 1'b1);
    wr(CTRL, 8'h08, 1'b0);
    rd(CTRL, 8'h00);
    $display("test 1 done");
    test_voltage <= 1'b1;
    arm(8'h06, PROT, 8'h0E);
    check({31'h0, pump_on}, 32'h1);
    wr(CTRL, 8'h0C, 1'b0);
    wr(CTRL, 8'h00, 1'b0);
    test_voltage <= 1'b0;
    rd(16'hE000, 8'hFF);
    rd(16'hFFFF, 8'hFF);
    rd(PROT, 8'hFF);
    $display("test 2 done");
    arm(8'h01, 16'hE020, 8'h09);
    wr(16'hE020, 8'h5A, 1'b0);
    rd(CTRL, 8'h09);
    wr(16'hE03F, 8'h00, 1'b0);
    wr(16'hE040, 8'h00, 1'b0);
    wr(CTRL, 8'h08, 1'b0);
    wr(CTRL, 8'h00, 1'b0);
    rd(16'hE020, 8'h5A);
    rd(16'hE03F, 8'h00);
    rd(16'hE040, 8'hFF);
    $display("test 3 done");
    arm(8'h02, 16'hE000, 8'h0A);
    wr(CTRL, 8'h08, 1'b0);
    wr(CTRL, 8'h00, 1'b0);
    rd(16'hE020, 8'hFF);
    rd(16'hE03F, 8'hFF);
    $display("test 4 done");
    arm(8'h01, PROT, 8'h09);
    wr(PROT, 8'hFE, 1'b0);
    wr(CTRL, 8'h08, 1'b0);
    wr(CTRL, 8'h00, 1'b0);
    rd(PROT, 8'hFE);
    arm(8'h01, 16'hFF80, 8'h01);
    wr(CTRL, 8'h00, 1'b0);
    arm(8'h01, PROT, 8'h01);
    wr(CTRL, 8'h00, 1'b0);
    arm(8'h01, 16'hFF40, 8'h09);
    $display("test 5 done");
    cpu_sleep <= 1'b1;
    repeat (3) @(posedge clk);
    check({30'h0, pump_on, array_standby}, 32'h1);
    cpu_sleep <= 1'b0;
    rd(CTRL, 8'h00);
    $display("test 6 done");
    results();
  end
endmodule
